//--- verilog/stod_pkg.sv
// Function
// (RULE1) Bytes 0-5 control, 6 reserved, 7 status, 8-10 CRC
// (RULE2) Decode bytes 0-5 by active function mode
// (RULE3) Multi-config: byte0 bits0-4 select bank A
// (RULE4) Multi-config: byte2 bits0-4 second selection A
// (RULE5) Two-function: byte0 bits0-4 select fields A
// (RULE6) Two-function: byte2 bits0-4 select fields B
// (RULE7) Byte4 bit0 warn, bit1 protect restart A
// (RULE8) Two-function: byte5 bit0/bit1 restart B
// (RULE9) Single-function: byte5 reserved, no B restart
// (RULE10) Four-field: byte0 bits0-4 shared group one
// (RULE11) Four-field: byte2 bits0-4 shared group two
// (RULE12) Reserved bits ignored when decoding
package stod_pkg;
   // Telegram layout
   localparam int TEL_BYTES    = 11;
   localparam int IDX_SEL1     = 0;
   localparam int IDX_SEL2     = 2;
   localparam int IDX_RSTA     = 4;
   localparam int IDX_RSTB     = 5;
   localparam int IDX_STATUS   = 7;
   localparam int IDX_CRC_HI   = 8;
   localparam int IDX_CRC_MID  = 9;
   localparam int IDX_CRC_LO   = 10;
   localparam int SEL_W        = 5;
   localparam int BIT_WARN     = 0;
   localparam int BIT_PROT     = 1;
   // APB register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_SELA   = 8'h04;
   localparam logic [7:0] OFF_SELB   = 8'h08;
   localparam logic [7:0] OFF_RST    = 8'h0C;
   localparam logic [7:0] OFF_STAT   = 8'h10;
   localparam logic [7:0] OFF_COUNT  = 8'h14;
   localparam logic [2:0] MODE_RESET = 3'h0;
   // Function modes
   typedef enum logic [2:0] {
      STOD_MODE_1F_5_10,
      STOD_MODE_1F_100,
      STOD_MODE_1F_MULTI,
      STOD_MODE_2F,
      STOD_MODE_2F_FOUR,
      STOD_MODE_2F_MULTI
   } stod_mode_e;
   // Receive states
   typedef enum logic [0:0] {
      STOD_IDLE,
      STOD_RECV
   } stod_state_e;
endpackage

//--- verilog/stod_decode_if.sv
`timescale 1ns/1ps
// Raw telegram bytes and mode between receiver and decoder
interface stod_decode_if;
   logic [7:0] byte0;  // Selection group one byte
   logic [7:0] byte2;  // Selection group two byte
   logic [7:0] byte4;  // Restart byte, function A
   logic [7:0] byte5;  // Restart byte, function B
   logic [2:0] mode;   // Active function mode
   logic [4:0] selA;   // Decoded selection for A
   logic [4:0] selB;   // Decoded selection for B
   logic       bankSel; // Selection is bank, not field
   logic [1:0] rstA;   // Restart requests A
   logic [1:0] rstB;   // Restart requests B
   modport master (output byte0, byte2, byte4, byte5, mode, input selA, selB, bankSel, rstA, rstB);
   modport decoder (input byte0, byte2, byte4, byte5, mode, output selA, selB, bankSel, rstA, rstB);
endinterface

//--- verilog/stod_mode_decoder.sv
`timescale 1ns/1ps
// Combinational mode-dependent decode of bytes 0..5
module stod_mode_decoder (
   stod_decode_if.decoder dif  // Bytes in, decoded fields out
);
   // Reserved bits are masked off by taking only the defined fields
   always_comb begin
      dif.selA    = '0;
      dif.selB    = '0;
      dif.bankSel = 1'b0;
      dif.rstA    = {dif.byte4[stod_pkg::BIT_PROT], dif.byte4[stod_pkg::BIT_WARN]}; // [RULE7] [RULE12]
      dif.rstB    = 2'h0;
      case (stod_pkg::stod_mode_e'(dif.mode)) // [RULE2]
         stod_pkg::STOD_MODE_1F_MULTI: begin
            dif.selA    = dif.byte0[stod_pkg::SEL_W-1:0]; // [RULE3]
            dif.bankSel = 1'b1;
            dif.selB    = dif.byte2[stod_pkg::SEL_W-1:0]; // [RULE4]
         end
         stod_pkg::STOD_MODE_2F: begin
            dif.selA = dif.byte0[stod_pkg::SEL_W-1:0]; // [RULE5]
            dif.selB = dif.byte2[stod_pkg::SEL_W-1:0]; // [RULE6]
            dif.rstB = {dif.byte5[stod_pkg::BIT_PROT], dif.byte5[stod_pkg::BIT_WARN]}; // [RULE8]
         end
         stod_pkg::STOD_MODE_2F_FOUR: begin
            dif.selA = dif.byte0[stod_pkg::SEL_W-1:0]; // [RULE10]
            dif.selB = dif.byte2[stod_pkg::SEL_W-1:0]; // [RULE11]
            dif.rstB = {dif.byte5[stod_pkg::BIT_PROT], dif.byte5[stod_pkg::BIT_WARN]};
         end
         stod_pkg::STOD_MODE_2F_MULTI: begin
            dif.selA    = dif.byte0[stod_pkg::SEL_W-1:0];
            dif.bankSel = 1'b1;
            dif.selB    = dif.byte2[stod_pkg::SEL_W-1:0];
            dif.rstB    = {dif.byte5[stod_pkg::BIT_PROT], dif.byte5[stod_pkg::BIT_WARN]};
         end
         default: begin
            // Single-function field modes: byte 5 ignored
            dif.selA = dif.byte0[stod_pkg::SEL_W-1:0]; // [RULE9]
            dif.selB = (stod_pkg::stod_mode_e'(dif.mode) == stod_pkg::STOD_MODE_1F_100) ?
                       dif.byte2[stod_pkg::SEL_W-1:0] : 5'h00;
         end
      endcase
   end
endmodule

//--- verilog/stod_top.sv
`timescale 1ns/1ps
// Safe output telegram decoder: byte stream in, decoded selections out
module stod_top (
   input  wire logic        mclk,        // 20 MHz clock
   input  wire logic        reset_n,     // Async reset, active low
   input  wire logic        telStart,    // Pulse: byte 0 of telegram on telData
   input  wire logic        telValid,    // Pulse: telData holds a byte
   input  wire logic [7:0]  telData,     // Telegram byte
   input  wire logic        telGood,     // Safety layer accepted status/CRC
   output logic [4:0]       selA,        // Selection, function A
   output logic [4:0]       selB,        // Selection, function B
   output logic             bankSel,     // Selection A is a configuration bank
   output logic [1:0]       rstA,        // Restart requests A {prot,warn}
   output logic [1:0]       rstB,        // Restart requests B {prot,warn}
   output logic             frameDone,   // Pulse: new telegram applied
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic [31:0]      prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr      // APB error
);
   stod_decode_if dif ();

   // Receive state
   stod_pkg::stod_state_e stateReg, stateNext;
   logic [3:0]  idxReg, idxNext;             // Byte index in telegram
   logic [7:0]  shadow0Reg, shadow0Next;     // Bytes being received
   logic [7:0]  shadow2Reg, shadow2Next;
   logic [7:0]  shadow4Reg, shadow4Next;
   logic [7:0]  shadow5Reg, shadow5Next;
   logic [7:0]  statusReg, statusNext;       // Safety status byte
   logic        fullReg, fullNext;           // All bytes seen
   logic [7:0]  act0Reg, act0Next;           // Applied telegram bytes
   logic [7:0]  act2Reg, act2Next;
   logic [7:0]  act4Reg, act4Next;
   logic [7:0]  act5Reg, act5Next;
   logic        doneReg, doneNext;
   logic [15:0] countReg, countNext;         // Applied telegram count
   // Registers
   logic [2:0]  modeReg, modeNext;           // Function mode
   logic [31:0] rdataReg, rdataNext;
   logic        errReg, errNext;
   // Outputs registered
   logic [4:0]  selAReg, selBReg;
   logic        bankReg;
   logic [1:0]  rstAReg, rstBReg;

   // Byte receive: bytes 0, 2, 4, 5 and the status byte are kept, CRC bytes are counted
   always_comb begin
      stateNext   = stateReg;
      idxNext     = idxReg;
      shadow0Next = shadow0Reg;
      shadow2Next = shadow2Reg;
      shadow4Next = shadow4Reg;
      shadow5Next = shadow5Reg;
      statusNext  = statusReg;
      fullNext    = fullReg;
      case (stateReg)
         stod_pkg::STOD_IDLE: begin
            if (telValid && telStart) begin
               shadow0Next = telData;
               idxNext     = 4'h1;
               fullNext    = 1'b0;
               stateNext   = stod_pkg::STOD_RECV;
            end
         end
         stod_pkg::STOD_RECV: begin
            if (telValid && telStart) begin
               // A fresh start aborts a partial telegram
               shadow0Next = telData;
               idxNext     = 4'h1;
               fullNext    = 1'b0;
            end else if (telValid) begin
               if (idxReg == 4'(stod_pkg::IDX_SEL2)) shadow2Next = telData; // [RULE1]
               else if (idxReg == 4'(stod_pkg::IDX_RSTA)) shadow4Next = telData;
               else if (idxReg == 4'(stod_pkg::IDX_RSTB)) shadow5Next = telData;
               else if (idxReg == 4'(stod_pkg::IDX_STATUS)) statusNext = telData;
               if (idxReg == 4'(stod_pkg::IDX_CRC_LO)) begin
                  fullNext  = 1'b1;
                  stateNext = stod_pkg::STOD_IDLE;
               end
               idxNext = idxReg + 4'h1;
            end
         end
         default: stateNext = stod_pkg::STOD_IDLE;
      endcase
   end

   // Apply a complete telegram once the safety layer accepts it, unless byte 0 of a new telegram arrives in that cycle
   always_comb begin
      act0Next  = act0Reg;
      act2Next  = act2Reg;
      act4Next  = act4Reg;
      act5Next  = act5Reg;
      doneNext  = 1'b0;
      countNext = countReg;
      if (fullReg && telGood && stateReg == stod_pkg::STOD_IDLE && !(telValid && telStart)) begin
         act0Next  = shadow0Reg;
         act2Next  = shadow2Reg;
         act4Next  = shadow4Reg;
         act5Next  = shadow5Reg;
         doneNext  = 1'b1;
         countNext = countReg + 16'h0001;
      end
   end

   // Receive registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stateReg   <= stod_pkg::STOD_IDLE;
         idxReg     <= 4'h0;
         shadow0Reg <= 8'h00;
         shadow2Reg <= 8'h00;
         shadow4Reg <= 8'h00;
         shadow5Reg <= 8'h00;
         statusReg  <= 8'h00;
         fullReg    <= 1'b0;
         act0Reg    <= 8'h00;
         act2Reg    <= 8'h00;
         act4Reg    <= 8'h00;
         act5Reg    <= 8'h00;
         doneReg    <= 1'b0;
         countReg   <= 16'h0000;
      end else begin
         stateReg   <= stateNext;
         idxReg     <= idxNext;
         shadow0Reg <= shadow0Next;
         shadow2Reg <= shadow2Next;
         shadow4Reg <= shadow4Next;
         shadow5Reg <= shadow5Next;
         statusReg  <= statusNext;
         fullReg    <= doneNext ? 1'b0 : fullNext;
         act0Reg    <= act0Next;
         act2Reg    <= act2Next;
         act4Reg    <= act4Next;
         act5Reg    <= act5Next;
         doneReg    <= doneNext;
         countReg   <= countNext;
      end
   end

   // Decoder feed from the next applied bytes, so outputs and frameDone move on the same edge
   assign dif.byte0 = act0Next;
   assign dif.byte2 = act2Next;
   assign dif.byte4 = act4Next;
   assign dif.byte5 = act5Next;
   assign dif.mode  = modeReg;

   stod_mode_decoder uDec (
      .dif (dif)
   );

   // Output flops; decoded values follow a mode change one edge after modeReg updates  [RULE2]
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         selAReg <= 5'h00;
         selBReg <= 5'h00;
         bankReg <= 1'b0;
         rstAReg <= 2'h0;
         rstBReg <= 2'h0;
      end else begin
         selAReg <= dif.selA;
         selBReg <= dif.selB;
         bankReg <= dif.bankSel;
         rstAReg <= dif.rstA;
         rstBReg <= dif.rstB;
      end
   end

   assign selA      = selAReg;
   assign selB      = selBReg;
   assign bankSel   = bankReg;
   assign rstA      = rstAReg;
   assign rstB      = rstBReg;
   assign frameDone = doneReg;

   // APB slave: zero wait states, error on unmapped address, bad mode or write to a read-only register
   always_comb begin
      modeNext  = modeReg;
      rdataNext = rdataReg;
      errNext   = 1'b0;
      if (psel && !penable) begin
         if (paddr == stod_pkg::OFF_CTRL) begin
            rdataNext = {29'h0, modeReg};
            if (pwrite) begin
               // Out-of-range codes, upper bits included, are refused and leave the mode unchanged
               if (pwdata > 32'(stod_pkg::STOD_MODE_2F_MULTI)) errNext = 1'b1;
            end
         end else if (paddr == stod_pkg::OFF_SELA) begin
            rdataNext = {26'h0, bankReg, selAReg};
            errNext   = pwrite;
         end else if (paddr == stod_pkg::OFF_SELB) begin
            rdataNext = {27'h0, selBReg};
            errNext   = pwrite;
         end else if (paddr == stod_pkg::OFF_RST) begin
            rdataNext = {28'h0, rstBReg, rstAReg};
            errNext   = pwrite;
         end else if (paddr == stod_pkg::OFF_STAT) begin
            rdataNext = {22'h0, fullReg, stateReg, statusReg};
            errNext   = pwrite;
         end else if (paddr == stod_pkg::OFF_COUNT) begin
            rdataNext = {16'h0, countReg};
            errNext   = pwrite;
         end else begin
            rdataNext = 32'h0000_0000;
            errNext   = 1'b1;
         end
      end
      // Mode write lands at the access edge, once the setup verdict is known
      if (psel && penable && pwrite && paddr == stod_pkg::OFF_CTRL && !errReg) begin
         modeNext = pwdata[2:0]; // [RULE2]
      end
   end

   // Register flops; read data and verdict prepared at setup, write done at access
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         modeReg  <= stod_pkg::MODE_RESET;
         rdataReg <= 32'h0000_0000;
         errReg   <= 1'b0;
      end else begin
         modeReg  <= modeNext;
         rdataReg <= rdataNext;
         errReg   <= errNext;
      end
   end

   assign prdata  = rdataReg;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & errReg;
endmodule

//--- verification/stod_top_asserts.sv
`timescale 1ns/1ps
// Watches the decoder pins; tracks byte positions itself
module stod_checker (
   input wire logic        mclk,      // Clock
   input wire logic        reset_n,   // Reset, active low
   input wire logic        telStart,  // Byte 0 marker
   input wire logic        telValid,  // Byte strobe
   input wire logic [7:0]  telData,   // Byte lane
   input wire logic        telGood,   // Safety verdict
   input wire logic [4:0]  selA,      // Selection A
   input wire logic [4:0]  selB,      // Selection B
   input wire logic        bankSel,   // Bank flag
   input wire logic [1:0]  rstA,      // Restart A
   input wire logic [1:0]  rstB,      // Restart B
   input wire logic        frameDone, // Applied pulse
   input wire logic        psel,      // APB select
   input wire logic        penable,   // APB enable
   input wire logic        pwrite,    // APB direction
   input wire logic [7:0]  paddr,     // APB address
   input wire logic [31:0] pwdata,    // APB write data
   input wire logic [31:0] prdata,    // APB read data
   input wire logic        pready,    // APB ready
   input wire logic        pslverr    // APB error
);
   logic [3:0] idx; // Next byte index, 0 before the first frame, 11 once a frame has ended
   logic [7:0] b0;  // Byte 0 of the latest frame
   logic [7:0] b4;  // Byte 4 of the latest frame
   wire        take = telValid && !telStart && idx != 4'h0 && idx < 4'hB; // Byte inside a frame
   wire        lastByte = take && idx == 4'hA; // Byte 10 arrives
   // Byte tracker; stray bytes outside a frame are not counted
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         idx <= 4'h0;
         b0  <= 8'h00;
         b4  <= 8'h00;
      end else if (telValid && telStart) begin
         idx <= 4'h1;
         b0  <= telData;
      end else if (take) begin
         idx <= idx + 4'h1;
         if (idx == 4'h4) begin
            b4 <= telData;
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence lastGood_s;
      lastByte && telGood;
   endsequence
   frame_latency_a: assert property (lastGood_s |-> ##2 frameDone)
      else $error("frame not applied two cycles after last byte");
   frame_refused_a: assert property (lastByte && !telGood |=> !frameDone [*2])
      else $error("frame applied without safety verdict");
   done_pulse_a: assert property (frameDone |=> !frameDone)
      else $error("frame pulse longer than one cycle");
   sela_value_a: assert property (frameDone |-> selA == b0[4:0])
      else $error("selection A differs from byte 0 low bits");
   rsta_value_a: assert property (frameDone |-> rstA == b4[1:0])
      else $error("restart A differs from byte 4 low bits");
   sela_hold_a: assert property (!frameDone |-> $stable(selA))
      else $error("selection A moved without a frame");
   rsta_hold_a: assert property (!frameDone |-> $stable(rstA))
      else $error("restart A moved without a frame");
   mode_refuse_a: assert property (psel && penable && pwrite && paddr == 8'h00 && pwdata > 32'h5 |-> pslverr)
      else $error("bad mode write not refused");
endmodule
bind stod_top stod_checker u_stod_checker (.mclk, .reset_n, .telStart, .telValid, .telData, .telGood, .selA,
   .selB, .bankSel, .rstA, .rstB, .frameDone, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

//--- verification/stod_plc_model.sv
`timescale 1ns/1ps
// Safety host: sends whole telegrams, one byte a cycle
module stod_plc_model (
   input  wire logic  mclk,     // Clock
   output logic       telStart, // Byte 0 marker
   output logic       telValid, // Byte strobe
   output logic [7:0] telData,  // Byte lane
   output logic       telGood   // Safety verdict
);
   initial begin
      telStart = 1'b0;
      telValid = 1'b0;
      telData  = 8'h00;
      telGood  = 1'b0;
   end
   // Reserved bytes go out as zero; status and CRC are filler here
   task automatic send(input logic [7:0] b0, b2, b4, b5, input logic good);
      logic [7:0] t [11];
      t = '{b0, 8'h00, b2, 8'h00, b4, b5, 8'h00, 8'h00, 8'hA1, 8'hB2, 8'hC3};
      for (int i = 0; i < 11; i++) begin
         @(posedge mclk);
         telStart <= (i == 0);
         telValid <= 1'b1;
         telData  <= t[i];
         telGood  <= good;
      end
      @(posedge mclk);
      telStart <= 1'b0;
      telValid <= 1'b0;
      telData  <= ~t[10]; // Released lane must not look like data
   endtask
   // Late verdict for a telegram held back
   task automatic setGood();
      @(posedge mclk);
      telGood <= 1'b1;
   endtask
endmodule

//--- verification/stod_top_bench.sv
`timescale 1ns/1ps
// Decoder bench: APB tasks plus host telegrams per mode
module stod_top_bench;
   logic        mclk = 1'b0;    // 20 MHz clock
   logic        reset_n = 1'b0; // Reset, active low
   logic        psel = 1'b0;    // APB select
   logic        penable = 1'b0; // APB enable
   logic        pwrite = 1'b0;  // APB direction
   logic [7:0]  paddr = 8'h00;  // APB address
   logic [31:0] pwdata = 32'h0; // APB write data
   logic [31:0] prdata, q;      // Read data, captured word
   logic        pready, pslverr, e, seen; // APB answer, captures
   logic        telStart, telValid, telGood, bankSel, frameDone; // Host strobes, flags
   logic [7:0]  telData;        // Byte lane
   logic [4:0]  selA, selB, s1, s2; // Selections and their stimulus
   logic [1:0]  rstA, rstB, ra, rb; // Restarts and their stimulus
   int          fail_count = 0; // Mismatches
   int          num_checks = 0; // Comparisons
   int          cyc = 0;        // Cycle count for the hang guard
   stod_top u_stod_top (.mclk, .reset_n, .telStart, .telValid, .telData, .telGood, .selA, .selB, .bankSel,
      .rstA, .rstB, .frameDone, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   stod_plc_model u_stod_plc_model (.mclk, .telStart, .telValid, .telData, .telGood);
   initial forever #25 mclk = ~mclk;
   // Hang guard: run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic summarize();
      if (fail_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         $display("Error %s expected %h seen %h", n, x, g);
         fail_count++;
      end
   endtask
   // One APB transfer, then an idle cycle so no strobe is set twice at one edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // Frame pulse is due two edges after the last byte
   task automatic waitDone();
      seen = 1'b0;
      repeat (6) begin
         @(posedge mclk);
         if (frameDone === 1'b1) seen = 1'b1;
      end
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (int m = 0; m < 6; m++) begin
         apb(1'b1, stod_pkg::OFF_CTRL, m);
         chk("ctrl err", 0, e);
         s1 = 5'h15 ^ 5'(m);
         s2 = 5'h0A + 5'(m);
         ra = 2'(m);
         rb = ~ra;
         // Reserved bits set high so the decoder must mask them
         u_stod_plc_model.send({3'h7, s1}, {3'h7, s2}, {6'h3F, ra}, {6'h3F, rb}, 1'b1);
         waitDone();
         chk("frameDone", 1, seen);
         chk("selA", s1, selA);
         chk("selB", (m != 0) ? s2 : 5'h00, selB);
         chk("bankSel", m == 2 || m == 5, bankSel);
         chk("rstA", ra, rstA);
         chk("rstB", (m >= 3) ? rb : 2'h0, rstB);
         apb(1'b0, stod_pkg::OFF_SELA, 0);
         chk("SELA reg", {(m == 2 || m == 5), s1}, q);
         apb(1'b0, stod_pkg::OFF_RST, 0);
         chk("RST reg", {((m >= 3) ? rb : 2'h0), ra}, q);
      end
      apb(1'b1, stod_pkg::OFF_CTRL, 0);
      repeat (3) @(posedge mclk);
      chk("rstB after mode change", 0, rstB);
      chk("bankSel after mode change", 0, bankSel);
      apb(1'b1, stod_pkg::OFF_CTRL, 6);
      chk("bad mode err", 1, e);
      apb(1'b0, stod_pkg::OFF_CTRL, 0);
      chk("mode kept", 0, q);
      apb(1'b0, 8'h18, 0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
      apb(1'b1, stod_pkg::OFF_STAT, 32'hFFFF);
      chk("read-only err", 1, e);
      u_stod_plc_model.send(8'h09, 8'h00, 8'h02, 8'h00, 1'b0);
      waitDone();
      chk("held frame", 0, seen);
      u_stod_plc_model.setGood();
      waitDone();
      chk("late frame", 1, seen);
      chk("late rstA", 2'h2, rstA);
      chk("late selA", 5'h09, selA);
      apb(1'b0, stod_pkg::OFF_COUNT, 0);
      chk("count", 7, q);
      summarize();
   end
endmodule
